//--- verilog/tsg_top.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "tsg_defs.svh"
module tsg_top #(
  parameter bit EOT_LATCH_DEFAULT = 1'b0,
  parameter bit RWD_UNSEL_DEFAULT = 1'b0,
  parameter int unsigned STOP_CYCLES =
    `TSG_STOP_MILS * `TSG_CLK_MHZ * 10000 / `TSG_SPEED_DIPS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transport pins
  input wire tsg_pkg::tsg_pins_t pins,
  // Status lines to the formatter
  output tsg_pkg::tsg_status_t status,
  // Motion drive
  output logic drive_forward,
  output logic drive_rewind,
  output logic write_mode
);
  localparam int REW_CYC = (`TSG_REW_MIN_NS * `TSG_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  tsg_pkg::tsg_pins_t pins_s;
  tsg_pkg::tsg_pins_t pins_prev_reg;
  logic rew_pulse;
  logic reu_pulse;

  tsg_sync #(.W($bits(tsg_pkg::tsg_pins_t))) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(pins),
    .q(pins_s)
  );

  // Short glitches on the command lines must not start a rewind
  tsg_pulse_qual #(.CYC(REW_CYC)) u_rew_qual (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(pins_s.rewind_command),
    .pulse(rew_pulse)
  );

  tsg_pulse_qual #(.CYC(REW_CYC)) u_reu_qual (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(pins_s.rewind_unload_command),
    .pulse(reu_pulse)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_prev_reg <= '0;
    end else begin
      pins_prev_reg <= pins_s;
    end
  end

  logic sel;
  logic reset_rise;
  logic online_rise;
  logic strobe_rise;
  logic eot_rev_exit;
  logic stopped_at_lp;

  assign sel = pins_s.unit_select_line[pins_s.unit_address];
  assign reset_rise = pins_s.reset_button && !pins_prev_reg.reset_button;
  assign online_rise = pins_s.online_button && !pins_prev_reg.online_button;
  assign strobe_rise = pins_s.write_char_strobe && !pins_prev_reg.write_char_strobe;
  assign eot_rev_exit = !pins_s.end_marker && pins_prev_reg.end_marker && pins_s.tape_reverse;
  assign stopped_at_lp = !pins_s.tape_moving && pins_s.load_point_marker;

  // ----------------------------------------------------------------
  // Online and load point tracking
  // ----------------------------------------------------------------
  logic online_reg;
  logic lp_seen_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      online_reg <= 1'b0;
    end else if (!pins_s.tension_ok || reset_rise || (reu_pulse && sel)) begin
      online_reg <= 1'b0;
    end else if (online_rise) begin
      online_reg <= !online_reg;
    end
  end

  // Tape wound on past the load point stays valid until tension drops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lp_seen_reg <= 1'b0;
    end else if (!pins_s.tension_ok) begin
      lp_seen_reg <= 1'b0;
    end else if (pins_s.load_point_marker) begin
      lp_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Motion sequencer
  // ----------------------------------------------------------------
  tsg_pkg::tsg_motion_t state_reg;
  logic ready_now;
  logic rew_go;
  logic run_go;

  assign ready_now = pins_s.tension_ok && lp_seen_reg && online_reg &&
                     (state_reg != tsg_pkg::TSG_REWIND);
  // Rewind is ignored with the tape already parked at the load point
  assign rew_go = sel && !stopped_at_lp &&
                  ((rew_pulse && online_reg) || reu_pulse);
  assign run_go = sel && ready_now && pins_s.run_forward_command;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= tsg_pkg::TSG_IDLE;
    end else begin
      case (state_reg)
        tsg_pkg::TSG_IDLE: begin
          if (rew_go) begin
            state_reg <= tsg_pkg::TSG_REWIND;
          end else if (run_go) begin
            state_reg <= tsg_pkg::TSG_RUN;
          end
        end
        tsg_pkg::TSG_RUN: begin
          if (!pins_s.run_forward_command || !pins_s.tension_ok) begin
            state_reg <= tsg_pkg::TSG_STOPPING;
          end
        end
        tsg_pkg::TSG_STOPPING: begin
          if (!pins_s.tape_moving) begin
            state_reg <= tsg_pkg::TSG_IDLE;
          end
        end
        tsg_pkg::TSG_REWIND: begin
          if (stopped_at_lp || !pins_s.tension_ok) begin
            state_reg <= tsg_pkg::TSG_IDLE;
          end
        end
        default: begin
          state_reg <= tsg_pkg::TSG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_forward <= 1'b0;
      drive_rewind <= 1'b0;
    end else begin
      drive_forward <= (state_reg == tsg_pkg::TSG_RUN);
      drive_rewind <= (state_reg == tsg_pkg::TSG_REWIND);
    end
  end

  // Write mode is caught only at the start of forward motion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      write_mode <= 1'b0;
    end else if (state_reg == tsg_pkg::TSG_IDLE && run_go && !rew_go) begin
      write_mode <= pins_s.set_write_command;
    end else if (state_reg != tsg_pkg::TSG_RUN) begin
      write_mode <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Stop distance watchdog and character count
  // ----------------------------------------------------------------
  logic [31:0] stop_cnt_reg;
  logic stop_fault_reg;
  logic [31:0] char_cnt_reg;
  logic apb_wr;
  logic clr_fault;
  logic clr_chars;
  logic char_inc;

  assign char_inc = strobe_rise && write_mode;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_cnt_reg <= 32'h0000_0000;
    end else if (state_reg != tsg_pkg::TSG_STOPPING) begin
      stop_cnt_reg <= 32'h0000_0000;
    end else if (stop_cnt_reg < STOP_CYCLES) begin
      stop_cnt_reg <= stop_cnt_reg + 32'h0000_0001;
    end
  end

  // A fault that arrives with the clear still sticks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_fault_reg <= 1'b0;
    end else if (stop_cnt_reg >= STOP_CYCLES) begin
      stop_fault_reg <= 1'b1;
    end else if (clr_fault) begin
      stop_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      char_cnt_reg <= 32'h0000_0000;
    end else if (clr_chars) begin
      char_cnt_reg <= char_inc ? 32'h0000_0001 : 32'h0000_0000;
    end else if (char_inc) begin
      char_cnt_reg <= char_cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // End marker latch and status lines
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic eot_latch_reg;
  tsg_pkg::tsg_status_t status_next;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      eot_latch_reg <= 1'b0;
    end else if (pins_s.end_marker) begin
      eot_latch_reg <= 1'b1;
    end else if (eot_rev_exit || !pins_s.tension_ok) begin
      eot_latch_reg <= 1'b0;
    end
  end

  always_comb begin
    status_next.unit_ready_status = sel && ready_now;
    status_next.online_status = sel && online_reg;
    status_next.rewinding_status = (sel || ctrl_reg[`TSG_CTRL_RWD_UNSEL]) &&
                                   (state_reg == tsg_pkg::TSG_REWIND);
    status_next.load_point_status = sel && stopped_at_lp;
    status_next.end_marker_status = sel && (ctrl_reg[`TSG_CTRL_EOT_LATCH] ?
                                    eot_latch_reg : pins_s.end_marker);
    status_next.write_protect_status = sel && pins_s.reel_protected;
    status_next.density_status = sel && pins_s.density_select;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic setup;
  logic [31:0] rd_mux;
  logic mapped;

  assign setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign clr_fault = apb_wr && (paddr == `TSG_OFF_STATUS) && pwdata[`TSG_STS_FAULT];
  assign clr_chars = apb_wr && (paddr == `TSG_OFF_CHARS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `TSG_OFF_CTRL) begin
      rd_mux[1:0] = ctrl_reg;
    end else if (paddr == `TSG_OFF_STATUS) begin
      rd_mux[6:0] = status;
      rd_mux[`TSG_STS_SELECTED] = sel;
      rd_mux[`TSG_STS_FAULT] = stop_fault_reg;
      rd_mux[`TSG_STS_STATE_LSB +: 4] = state_reg;
      rd_mux[`TSG_STS_WRITE] = write_mode;
    end else if (paddr == `TSG_OFF_CHARS) begin
      rd_mux = char_cnt_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg <= {RWD_UNSEL_DEFAULT, EOT_LATCH_DEFAULT};
    end else if (apb_wr && paddr == `TSG_OFF_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rewind_running;
    state_reg == tsg_pkg::TSG_REWIND && !stopped_at_lp && pins_s.tension_ok;
  endsequence

  a_ready_terms: assert property (status.unit_ready_status |->
    $past(online_reg && lp_seen_reg && pins_s.tension_ok) && !status.rewinding_status)
    else $error("ready shown without its conditions");
  a_online_clear: assert property ((reset_rise || !pins_s.tension_ok) |=>
    !online_reg ##1 !status.online_status)
    else $error("online not cleared");
  a_online_tension: assert property (online_reg |-> $past(pins_s.tension_ok))
    else $error("online without tension");
  a_rewind_hold: assert property (s_rewind_running |=>
    state_reg == tsg_pkg::TSG_REWIND)
    else $error("rewind released early");
  a_rewind_unsel: assert property (status.rewinding_status && !$past(sel) |->
    $past(ctrl_reg[`TSG_CTRL_RWD_UNSEL]))
    else $error("rewinding shown unselected");
  a_lp_status: assert property (status.load_point_status |->
    $past(!pins_s.tape_moving && pins_s.load_point_marker))
    else $error("load point shown while moving");
  a_eot_latch: assert property (ctrl_reg[`TSG_CTRL_EOT_LATCH] && eot_latch_reg &&
    !eot_rev_exit && pins_s.tension_ok && !pins_s.end_marker |=> eot_latch_reg)
    else $error("end marker latch lost");
  a_protect_density: assert property ((status.write_protect_status ||
    status.density_status) |-> $past(sel))
    else $error("status shown for unselected unit");
  a_rewind_pulse: assert property ($rose(pins_s.rewind_command) ##1
    pins_s.rewind_command [*8] ##1 !pins_s.rewind_command |-> !$past(rew_pulse))
    else $error("short rewind accepted");
  a_stop_release: assert property (state_reg == tsg_pkg::TSG_RUN &&
    !pins_s.run_forward_command |=> ##1 !drive_forward)
    else $error("forward drive not released");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("apb access phase without ready");
endmodule // tsg_top

//--- verilog/tsg_defs.svh
`ifndef TSG_DEFS_SVH
`define TSG_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSG_CLK_MHZ 250
`define TSG_REW_MIN_NS 1000
`define TSG_STOP_MILS 190
`define TSG_SPEED_DIPS 375

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TSG_OFF_CTRL 12'h000
`define TSG_OFF_STATUS 12'h004
`define TSG_OFF_CHARS 12'h008

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TSG_CTRL_EOT_LATCH 0
`define TSG_CTRL_RWD_UNSEL 1
`define TSG_STS_SELECTED 7
`define TSG_STS_FAULT 8
`define TSG_STS_STATE_LSB 12
`define TSG_STS_WRITE 16
`define TSG_CTRL_RESET 2'h0

`endif

//--- verilog/tsg_pkg.sv
package tsg_pkg;

  // Transport pins as seen from the formatter cable and the deck sensors
  typedef struct packed {
    logic [3:0] unit_select_line;
    logic [1:0] unit_address;
    logic run_forward_command;
    logic set_write_command;
    logic rewind_command;
    logic rewind_unload_command;
    logic density_select;
    logic tension_ok;
    logic reset_button;
    logic online_button;
    logic load_point_marker;
    logic end_marker;
    logic tape_moving;
    logic tape_reverse;
    logic reel_protected;
    logic write_char_strobe;
  } tsg_pins_t;

  typedef struct packed {
    logic unit_ready_status;
    logic online_status;
    logic rewinding_status;
    logic load_point_status;
    logic end_marker_status;
    logic write_protect_status;
    logic density_status;
  } tsg_status_t;

  typedef enum logic [3:0] {
    TSG_IDLE = 4'h1,
    TSG_RUN = 4'h2,
    TSG_STOPPING = 4'h4,
    TSG_REWIND = 4'h8
  } tsg_motion_t;

endpackage

//--- verilog/tsg_sync.sv
`timescale 1ns/1ns
module tsg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // tsg_sync

//--- verilog/tsg_pulse_qual.sv
`timescale 1ns/1ns
module tsg_pulse_qual #(
  parameter int CYC = 250
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Level in, one-shot out
  input wire logic level,
  output logic pulse
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_reg;

  // One pulse per assertion held for at least CYC cycles, however long it is held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= level && (cnt_reg == LAST);
      if (!level) begin
        cnt_reg <= '0;
      end else if (cnt_reg <= LAST) begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end
endmodule // tsg_pulse_qual

//--- test/tsg_fmt_model.sv
`timescale 1ns/1ns
module tsg_fmt_model #(
  parameter int PRE_CYC = 40,
  parameter int POST_CYC = 30,
  parameter int SWRT_CYC = 2600
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Status from the transport
  input wire tsg_pkg::tsg_status_t status,
  // Command lines
  output logic run_forward_command,
  output logic set_write_command,
  output logic rewind_command,
  output logic write_char_strobe
);
  logic frame_on = 1'h0;
  int n_sent = 0;

  // --------------------------------
  // Character strobe, 64 ns, only inside a record
  // --------------------------------
  initial begin
    run_forward_command = 1'h0;
    set_write_command = 1'h0;
    rewind_command = 1'h0;
    write_char_strobe = 1'h0;
    #3;
    forever begin
      #32;
      write_char_strobe = frame_on & ~write_char_strobe;
    end
  end

  always @(posedge write_char_strobe) n_sent++;

  // --------------------------------
  // Program sequences
  // --------------------------------
  // Load point only matters for the first record, so only ready is checked here
  task automatic write_record(input int nc, output bit ok);
    int base;
    ok = (status.unit_ready_status === 1'h1);
    if (ok) begin
      set_write_command <= 1'h1;
      repeat (4) @(posedge clk_sys);
      run_forward_command <= 1'h1;
      repeat (SWRT_CYC) @(posedge clk_sys);
      set_write_command <= 1'h0;
      repeat (PRE_CYC) @(posedge clk_sys);
      base = n_sent;
      frame_on = 1'h1;
      while (n_sent < base + nc + 2) @(posedge clk_sys);
      frame_on = 1'h0;
      repeat (POST_CYC) @(posedge clk_sys);
      run_forward_command <= 1'h0;
    end
  endtask

  task automatic rewind(input int cyc);
    rewind_command <= 1'h1;
    repeat (cyc) @(posedge clk_sys);
    rewind_command <= 1'h0;
    @(posedge clk_sys);
  endtask
endmodule // tsg_fmt_model

//--- test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int STOP = 50;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, drive_forward, drive_rewind, write_mode;
  logic fwd, swrt, rew, wcs;
  logic mv = 1'h0;
  logic stuck = 1'h0;
  logic [1:0] ua;
  tsg_pkg::tsg_pins_t dk = '0;
  tsg_pkg::tsg_pins_t pins;
  tsg_pkg::tsg_status_t status;
  int mismatches = 0;
  int n_tests = 0;
  int tnum = 0;
  int nc, m_online, m_lp, m_rew, m_eotl, m_ctrl;
  bit ok;

  always #2 clk_sys = ~clk_sys;

  tsg_top #(.STOP_CYCLES(STOP)) i_tsg_top (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .status(status),
    .drive_forward(drive_forward), .drive_rewind(drive_rewind), .write_mode(write_mode));
  tsg_fmt_model i_tsg_fmt_model (.clk_sys(clk_sys), .rst(rst), .status(status),
    .run_forward_command(fwd), .set_write_command(swrt), .rewind_command(rew),
    .write_char_strobe(wcs));

  // --------------------------------
  // Deck: tape runs while driven, a rewind stops on the marker
  // --------------------------------
  always_comb begin
    pins = dk;
    pins.run_forward_command = fwd;
    pins.set_write_command = swrt;
    pins.rewind_command = rew;
    pins.write_char_strobe = wcs;
    pins.tape_moving = mv;
  end
  always @(posedge clk_sys) mv <= stuck | drive_forward | (drive_rewind & ~dk.load_point_marker);

  // --------------------------------
  // Model and tasks
  // --------------------------------
  function automatic logic [7:0] exp_sts();
    logic s;
    s = dk.unit_select_line[dk.unit_address];
    return {s, s & dk.tension_ok & m_lp[0] & m_online[0] & ~m_rew[0], s & m_online[0],
      (s | m_ctrl[1]) & m_rew[0], s & ~mv & dk.load_point_marker,
      s & (dk.end_marker | m_eotl[0]), s & dk.reel_protected, s & dk.density_select};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic chk_sts();
    logic [7:0] e;
    dk.density_select <= 1'($urandom);
    dk.reel_protected <= 1'($urandom);
    repeat (12) @(posedge clk_sys);
    e = exp_sts();
    chk({25'h0, status}, {25'h0, e[6:0]});
    apb(1'h0, 12'h004, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, e});
  endtask

  // Buttons are held long enough to pass the command qualifier too
  task automatic btn(input int k);
    for (int v = 1; v >= 0; v--) begin
      case (k)
        0: dk.reset_button <= v[0];
        1: dk.online_button <= v[0];
        default: dk.rewind_unload_command <= v[0];
      endcase
      repeat (300) @(posedge clk_sys);
    end
  endtask

  task automatic tend();
    tnum++;
    $display("test %0d finished", tnum);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(93890));
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    chk_sts();
    apb(1'h1, 12'h00C, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    tend();
    ua = 2'($urandom_range(3));
    dk.unit_address <= ua;
    dk.unit_select_line <= 4'h1 << ua;
    dk.tension_ok <= 1'h1;
    dk.load_point_marker <= 1'h1;
    m_lp = 1;
    chk_sts();
    btn(1);
    m_online = 1;
    chk_sts();
    tend();
    nc = $urandom_range(20, 5);
    fork
      i_tsg_fmt_model.write_record(nc, ok);
      begin
        repeat (600) @(posedge clk_sys);
        dk.load_point_marker <= 1'h0;
        chk({30'h0, drive_forward, write_mode}, 32'h3);
      end
    join
    chk({31'h0, ok}, 32'h1);
    chk_sts();
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'(nc + 2));
    apb(1'h0, 12'h004, 32'h0);
    chk({23'h0, rd[16:8]}, 32'h10);
    tend();
    stuck <= 1'h1;
    i_tsg_fmt_model.write_record(1, ok);
    repeat (STOP + 20) @(posedge clk_sys);
    apb(1'h0, 12'h004, 32'h0);
    chk({31'h0, rd[8]}, 32'h1);
    stuck <= 1'h0;
    // The fault keeps setting until the coasting tape is seen stopped
    repeat (8) @(posedge clk_sys);
    apb(1'h1, 12'h004, 32'h100);
    apb(1'h0, 12'h004, 32'h0);
    chk({31'h0, rd[8]}, 32'h0);
    tend();
    i_tsg_fmt_model.rewind(9);
    i_tsg_fmt_model.rewind(100);
    chk_sts();
    i_tsg_fmt_model.rewind(300);
    m_rew = 1;
    chk_sts();
    chk({31'h0, drive_rewind}, 32'h1);
    apb(1'h1, 12'h000, 32'h2);
    m_ctrl = 2;
    dk.unit_select_line <= 4'h0;
    chk_sts();
    dk.unit_select_line <= 4'h1 << ua;
    apb(1'h1, 12'h000, 32'h0);
    m_ctrl = 0;
    dk.load_point_marker <= 1'h1;
    m_rew = 0;
    chk_sts();
    i_tsg_fmt_model.rewind(300);
    chk_sts();
    tend();
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, 12'h000, 32'(k));
      m_ctrl = k;
      dk.end_marker <= 1'h1;
      chk_sts();
      dk.end_marker <= 1'h0;
      m_eotl = k;
      chk_sts();
      dk.tape_reverse <= 1'h1;
      dk.end_marker <= 1'h1;
      repeat (8) @(posedge clk_sys);
      dk.end_marker <= 1'h0;
      m_eotl = 0;
      chk_sts();
      dk.tape_reverse <= 1'h0;
    end
    tend();
    for (int k = 0; k < 3; k++) begin
      if (k == 2) dk.load_point_marker <= 1'h0;
      btn(k);
      m_online = 0;
      m_rew = (k == 2);
      chk_sts();
      dk.load_point_marker <= 1'h1;
      m_rew = 0;
      chk_sts();
      btn(1);
      m_online = 1;
      chk_sts();
    end
    dk.tension_ok <= 1'h0;
    m_online = 0;
    m_lp = 0;
    chk_sts();
    tend();
    summarize();
  end
endmodule // tb_top
